// file: hw/pesd_top.sv
// Event select decoder: picks the core condition that steps each counter
// How it works
// R1: Code 28H masks pick writeback line states
// R2: Code 28H mask 0FH counts every writeback
// R3: Code 2EH mask 41H counts last-level misses
// R4: Code 2EH mask 4FH counts last-level references
// R5: Code 3CH mask 00H counts unhalted cycles
// R6: Code 3CH mask 01H counts unhalted reference ticks
// R7: Code 49H mask 01H counts walk-starting misses
// R8: Code 49H mask 02H counts completed walks
// R9: Code 49H mask 04H counts walk busy cycles
// R10: Code 49H mask 10H counts second-level hits
// R11: Code 49H mask 20H counts low-address misses
// R12: Code 49H mask 80H counts completed large walks
// R13: Code 4CH counts loads hitting pending prefetch
// R14: Code 4EH mask 01H counts dispatched prefetches
// R15: Code 4EH mask 02H counts missing prefetches
// R16: Streamer stops on hit, pointer prefetcher continues
// R17: Code 4EH mask 04H counts queue pushes
// R18: Triggers may be dropped, exceeding dispatches
// R19: Code 4FH mask 10H counts nested walk cycles
// R20: Matching selection adds one, else holds
// R21: Undefined selections count nothing
`timescale 1ns/1ps
module pesd_top #(
  parameter int NUM_CNT = `PESD_NUM_CNT,
  parameter int LOW_CNT = `PESD_LOW_CNT,
  parameter int CNT_W   = `PESD_CNT_W,
  parameter int PFQ_D   = `PESD_PFQ_DEPTH
) (
  input  logic                   i_clock,
  input  logic                   i_rst,
  input  pesd_pkg::pesd_sel_s    i_sel [NUM_CNT],
  input  pesd_pkg::pesd_mem_ev_s i_ev,
  input  pesd_pkg::pesd_pf_req_s i_stream_req,
  input  pesd_pkg::pesd_pf_req_s i_ip_req,
  input  logic                   i_stream_restart,
  input  logic                   i_disp_ready,
  input  logic                   i_disp_hit,
  output logic                   o_disp_valid,
  output pesd_pkg::pesd_pf_req_s o_disp_req,
  output logic                   o_streamer_stopped,
  output logic [CNT_W-1:0]       o_count [NUM_CNT]
);
  import pesd_pkg::*;

  logic             pf_trigger;
  logic             pf_dispatch;
  logic             pf_miss;
  logic [NUM_CNT-1:0] cnt_inc;

  pesd_prefetch_queue #(
    .DEPTH(PFQ_D)
  ) u_pfq (
    .i_clock           (i_clock),
    .i_rst             (i_rst),
    .i_stream_req      (i_stream_req),
    .i_ip_req          (i_ip_req),
    .i_stream_restart  (i_stream_restart),
    .i_disp_ready      (i_disp_ready),
    .i_disp_hit        (i_disp_hit),
    .o_disp_valid      (o_disp_valid),
    .o_disp_req        (o_disp_req),
    .o_streamer_stopped(o_streamer_stopped),
    .o_trigger         (pf_trigger),
    .o_dispatch        (pf_dispatch),
    .o_miss            (pf_miss)
  );

  // One decode per counter; low_ok marks the counters that may take
  // the prefetch-related events, others simply never see them
  function automatic logic decode(input pesd_sel_s s, input logic low_ok);
    logic hit;
    hit = 1'b0;
    if (s.en) begin
      unique case (s.code)
        `PESD_EV_WB: begin
          if (s.umask == `PESD_UM_01 || s.umask == `PESD_UM_02 ||
              s.umask == `PESD_UM_04 || s.umask == `PESD_UM_08 ||
              s.umask == `PESD_UM_0F) begin
            // Mask bits line up with the one-hot line state
            hit = i_ev.wb_valid && |(i_ev.wb_state & s.umask[3:0]); // see R1 see R2
          end
        end
        `PESD_EV_LLC: begin
          if (s.umask == `PESD_UM_41) begin
            hit = i_ev.llc_miss; // see R3
          end else if (s.umask == `PESD_UM_4F) begin
            hit = i_ev.llc_ref; // see R4
          end
        end
        `PESD_EV_UNHALTED: begin
          if (s.umask == `PESD_UM_00) begin
            hit = !i_ev.halted; // see R5
          end else if (s.umask == `PESD_UM_01) begin
            hit = !i_ev.halted && i_ev.tsc_tick; // see R6
          end
        end
        `PESD_EV_XLATE: begin
          unique case (s.umask)
            `PESD_UM_01: hit = i_ev.walk_start; // see R7
            `PESD_UM_02: hit = i_ev.walk_done; // see R8
            `PESD_UM_04: hit = i_ev.walk_busy; // see R9
            `PESD_UM_10: hit = i_ev.second_level_translation_buffer_hit; // see R10
            `PESD_UM_20: hit = i_ev.pde_miss; // see R11
            `PESD_UM_80: hit = i_ev.large_walk_done; // see R12
            default:     hit = 1'b0; // see R21
          endcase
        end
        `PESD_EV_LOAD_PRE: begin
          if (s.umask == `PESD_UM_01) begin
            hit = low_ok && i_ev.load_hit_pre; // see R13
          end
        end
        `PESD_EV_PREFETCH: begin
          unique case (s.umask)
            `PESD_UM_01: hit = low_ok && pf_dispatch; // see R14
            `PESD_UM_02: hit = low_ok && pf_miss; // see R15
            `PESD_UM_04: hit = low_ok && pf_trigger; // see R17
            default:     hit = 1'b0; // see R21
          endcase
        end
        `PESD_EV_NESTED: begin
          if (s.umask == `PESD_UM_10) begin
            hit = i_ev.nested_walk_busy; // see R19
          end
        end
        default: hit = 1'b0; // see R21
      endcase
    end
    decode = hit;
  endfunction : decode

  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++) begin : g_cnt
      always_comb begin
        cnt_inc[g] = decode(i_sel[g], g < LOW_CNT); // see R20
      end

      pesd_event_counter #(
        .W(CNT_W)
      ) u_cnt (
        .i_clock(i_clock),
        .i_rst  (i_rst),
        .i_inc  (cnt_inc[g]),
        .o_count(o_count[g])
      );
    end
  endgenerate

  // Checks below watch counter 0 and, for the restricted events, the last counter
  wb_state_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R1
    i_sel[0].en && i_sel[0].code == `PESD_EV_WB && i_sel[0].umask == `PESD_UM_02
      && i_ev.wb_valid && i_ev.wb_state != PESD_LINE_S
      |=> $stable(o_count[0]))
    else $error("writeback of another line state counted");

  wb_any_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R2
    i_sel[0].en && i_sel[0].code == `PESD_EV_WB && i_sel[0].umask == `PESD_UM_0F
      && i_ev.wb_valid |=> o_count[0] == $past(o_count[0]) + CNT_W'(1))
    else $error("writeback not counted");

  llc_miss_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R3
    i_sel[0].en && i_sel[0].code == `PESD_EV_LLC && i_sel[0].umask == `PESD_UM_41
      |-> cnt_inc[0] == i_ev.llc_miss)
    else $error("last-level miss selection wrong");

  llc_ref_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R4
    i_sel[0].en && i_sel[0].code == `PESD_EV_LLC && i_sel[0].umask == `PESD_UM_4F
      && i_ev.llc_ref ##1 1'b1 |-> o_count[0] != $past(o_count[0]))
    else $error("last-level reference not counted");

  unhalted_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R5
    (i_sel[0] == {1'b1, `PESD_EV_UNHALTED, `PESD_UM_00} && !i_ev.halted) [*2]
      |=> o_count[0] == $past(o_count[0], 2) + CNT_W'(2))
    else $error("unhalted cycles not counted each cycle");

  ref_tick_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R6
    i_sel[0] == {1'b1, `PESD_EV_UNHALTED, `PESD_UM_01}
      && (i_ev.halted || !i_ev.tsc_tick) |=> $stable(o_count[0]))
    else $error("reference count moved off tick or while halted");

  walk_start_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R7
    i_sel[0] == {1'b1, `PESD_EV_XLATE, `PESD_UM_01} |-> cnt_inc[0] == i_ev.walk_start)
    else $error("walk start selection wrong");

  walk_done_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R8
    i_sel[0] == {1'b1, `PESD_EV_XLATE, `PESD_UM_02} |-> cnt_inc[0] == i_ev.walk_done)
    else $error("walk completion selection wrong");

  walk_busy_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R9
    (i_sel[0] == {1'b1, `PESD_EV_XLATE, `PESD_UM_04} && i_ev.walk_busy) [*3]
      |=> o_count[0] == $past(o_count[0], 3) + CNT_W'(3))
    else $error("walk busy cycles not counted");

  second_level_translation_buffer_hit_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R10
    i_sel[0] == {1'b1, `PESD_EV_XLATE, `PESD_UM_10} |-> cnt_inc[0] == i_ev.second_level_translation_buffer_hit)
    else $error("second-level hit selection wrong");

  pde_miss_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R11
    i_sel[0] == {1'b1, `PESD_EV_XLATE, `PESD_UM_20} |-> cnt_inc[0] == i_ev.pde_miss)
    else $error("low-address miss selection wrong");

  large_walk_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R12
    i_sel[0] == {1'b1, `PESD_EV_XLATE, `PESD_UM_80}
      |-> cnt_inc[0] == i_ev.large_walk_done)
    else $error("large walk selection wrong");

  load_pre_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R13
    i_sel[NUM_CNT-1].code == `PESD_EV_LOAD_PRE && NUM_CNT > LOW_CNT
      |=> $stable(o_count[NUM_CNT-1]))
    else $error("restricted event counted on a high counter");

  pf_disp_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R14
    i_sel[0] == {1'b1, `PESD_EV_PREFETCH, `PESD_UM_01} |-> cnt_inc[0] == pf_dispatch)
    else $error("prefetch dispatch selection wrong");

  pf_miss_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R15
    i_sel[0] == {1'b1, `PESD_EV_PREFETCH, `PESD_UM_02} && i_disp_hit
      |-> !cnt_inc[0])
    else $error("prefetch hit counted as miss");

  pf_trig_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R17
    i_sel[0] == {1'b1, `PESD_EV_PREFETCH, `PESD_UM_04}
      && (i_ip_req.valid || i_stream_req.valid && !o_streamer_stopped)
      |=> o_count[0] == $past(o_count[0]) + CNT_W'(1))
    else $error("prefetch trigger not counted");

  // A dropped or never-written slot must not reach the dispatch port
  pf_drop_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R18
    pf_dispatch |-> o_disp_req.valid)
    else $error("dispatch without a queued request");

  nested_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R19
    i_sel[0] == {1'b1, `PESD_EV_NESTED, `PESD_UM_10}
      |-> cnt_inc[0] == i_ev.nested_walk_busy)
    else $error("nested walk cycle selection wrong");

  disabled_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R20
    !i_sel[0].en [*2] |=> o_count[0] == $past(o_count[0], 2))
    else $error("disabled counter moved");

  undefined_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R21
    i_sel[0].code == `PESD_EV_LLC && i_sel[0].umask == `PESD_UM_01
      |=> $stable(o_count[0]))
    else $error("undefined selection counted");
endmodule : pesd_top

// file: hw/pesd_consts.svh
// Event codes, unit masks, widths and sizes of the event select decoder
`ifndef PESD_CONSTS_SVH
`define PESD_CONSTS_SVH

`define PESD_EV_WB         8'h28
`define PESD_EV_LLC        8'h2e
`define PESD_EV_UNHALTED   8'h3c
`define PESD_EV_XLATE      8'h49
`define PESD_EV_LOAD_PRE   8'h4c
`define PESD_EV_PREFETCH   8'h4e
`define PESD_EV_NESTED     8'h4f

`define PESD_UM_00         8'h00
`define PESD_UM_01         8'h01
`define PESD_UM_02         8'h02
`define PESD_UM_04         8'h04
`define PESD_UM_08         8'h08
`define PESD_UM_0F         8'h0f
`define PESD_UM_10         8'h10
`define PESD_UM_20         8'h20
`define PESD_UM_41         8'h41
`define PESD_UM_4F         8'h4f
`define PESD_UM_80         8'h80

`define PESD_NUM_CNT       4
`define PESD_LOW_CNT       2
`define PESD_CNT_W         48
`define PESD_CNT_RESET     48'h0
`define PESD_PFQ_DEPTH     4
`define PESD_LINE_W        26

`endif

// file: hw/pesd_pkg.sv
// Types shared by the event select decoder files
package pesd_pkg;
  `include "pesd_consts.svh"

  // Line state one-hot, bit order matches the writeback unit mask bits
  typedef enum logic [3:0] {
    PESD_LINE_I = 4'b0001,
    PESD_LINE_S = 4'b0010,
    PESD_LINE_E = 4'b0100,
    PESD_LINE_M = 4'b1000
  } pesd_line_e;

  typedef enum logic [1:0] {
    PESD_STR_RUN  = 2'b01,
    PESD_STR_STOP = 2'b10
  } pesd_stream_e;

  typedef struct packed {
    logic       en;
    logic [7:0] code;
    logic [7:0] umask;
  } pesd_sel_s;

  typedef struct packed {
    logic       wb_valid;
    pesd_line_e wb_state;
    logic       llc_miss;
    logic       llc_ref;
    logic       halted;
    logic       tsc_tick;
    logic       walk_start;
    logic       walk_done;
    logic       walk_busy;
    logic       second_level_translation_buffer_hit;
    logic       pde_miss;
    logic       large_walk_done;
    logic       load_hit_pre;
    logic       nested_walk_busy;
  } pesd_mem_ev_s;

  typedef struct packed {
    logic                    valid;
    logic                    streamer;
    logic [`PESD_LINE_W-1:0] line;
  } pesd_pf_req_s;
endpackage : pesd_pkg

// file: hw/pesd_event_counter.sv
// One general event counter: adds one on each qualified cycle
`timescale 1ns/1ps
module pesd_event_counter #(
  parameter int W = `PESD_CNT_W
) (
  input  logic         i_clock,
  input  logic         i_rst,
  input  logic         i_inc,
  output logic [W-1:0] o_count
);
  import pesd_pkg::*;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_count <= W'(`PESD_CNT_RESET);
    end else if (i_inc) begin // see R20
      o_count <= o_count + W'(1);
    end
  end

  cnt_step_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R20
    i_inc |=> o_count == $past(o_count) + W'(1))
    else $error("counter missed an increment");

  cnt_hold_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R20
    !i_inc |=> $stable(o_count))
    else $error("counter moved without an event");
endmodule : pesd_event_counter

// file: hw/pesd_prefetch_queue.sv
// Hardware prefetch queue shared by the streamer and the pointer-based prefetcher
`timescale 1ns/1ps
module pesd_prefetch_queue #(
  parameter int DEPTH = `PESD_PFQ_DEPTH
) (
  input  logic                  i_clock,
  input  logic                  i_rst,
  input  pesd_pkg::pesd_pf_req_s i_stream_req,
  input  pesd_pkg::pesd_pf_req_s i_ip_req,
  input  logic                  i_stream_restart,
  input  logic                  i_disp_ready,
  input  logic                  i_disp_hit,
  output logic                  o_disp_valid,
  output pesd_pkg::pesd_pf_req_s o_disp_req,
  output logic                  o_streamer_stopped,
  output logic                  o_trigger,
  output logic                  o_dispatch,
  output logic                  o_miss
);
  import pesd_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH + 1);

  pesd_pf_req_s mem [DEPTH];
  logic [AW-1:0] wr;
  logic [AW-1:0] rd;
  logic [LW-1:0] level;
  pesd_stream_e  stream;
  pesd_pf_req_s  push_req;
  logic          push;
  logic          pop;
  logic          full;
  logic          overwrite;
  logic          stream_ok;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : next_ptr

  // A stopped streamer offers nothing; on a clash the pointer-based one wins
  always_comb begin
    stream_ok = i_stream_req.valid && (stream == PESD_STR_RUN); // see R16
    push      = i_ip_req.valid || stream_ok;
    push_req  = i_ip_req.valid ? i_ip_req : i_stream_req; // see R18
    push_req.valid = 1'b1;
  end

  assign full         = (level == LW'(DEPTH));
  assign o_disp_valid = (level != '0);
  assign o_disp_req   = mem[rd];
  assign pop          = o_disp_valid && i_disp_ready;
  // Full queue drops its oldest entry rather than stall the trigger logic
  assign overwrite    = push && full && !pop; // see R18
  assign o_trigger    = push; // see R17
  assign o_dispatch   = pop; // see R14
  assign o_miss       = pop && !i_disp_hit; // see R15
  assign o_streamer_stopped = (stream == PESD_STR_STOP);

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr] <= push_req;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wr    <= '0;
      rd    <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr <= next_ptr(wr);
      end
      if (pop || overwrite) begin
        rd <= next_ptr(rd);
      end
      if (push && !pop && !full) begin
        level <= level + LW'(1);
      end else if (pop && !push) begin
        level <= level - LW'(1);
      end
    end
  end

  // Stopping on a hit wins over a restart in the same cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      stream <= PESD_STR_RUN;
    end else begin
      unique case (stream)
        PESD_STR_RUN: begin
          if (pop && mem[rd].streamer && i_disp_hit) begin // see R16
            stream <= PESD_STR_STOP;
          end
        end
        PESD_STR_STOP: begin
          if (i_stream_restart && !(pop && mem[rd].streamer && i_disp_hit)) begin
            stream <= PESD_STR_RUN;
          end
        end
        default: stream <= PESD_STR_RUN;
      endcase
    end
  end

  stream_stop_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R16
    pop && mem[rd].streamer && i_disp_hit |=> o_streamer_stopped)
    else $error("streamer kept running after a hit");

  ip_keeps_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R16
    !o_streamer_stopped && pop && !mem[rd].streamer && !i_stream_restart
      |=> !o_streamer_stopped)
    else $error("pointer prefetcher hit stopped the streamer");

  queue_bound_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R17
    level <= LW'(DEPTH))
    else $error("prefetch queue over its depth");

  drop_full_a: assert property (@(posedge i_clock) disable iff (i_rst) // see R18
    overwrite |=> full && rd == next_ptr($past(rd)))
    else $error("full queue did not drop its oldest entry");
endmodule : pesd_prefetch_queue

// file: bench/pesd_dcache_model.sv
// Data cache side model: takes queued prefetches after a programmable stall
`timescale 1ns/1ps
module pesd_dcache_model (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_disp_valid,
  input  wire logic [7:0] i_stall,
  input  wire logic       i_hit,
  output logic            o_disp_ready,
  output logic            o_disp_hit
);
  logic [7:0] waited;

  // Answers only while a request stands, so it never pops an empty queue
  always_ff @(negedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_disp_ready <= 1'b0;
      waited       <= 8'h00;
    end else if (i_disp_valid && waited >= i_stall) begin
      o_disp_ready <= 1'b1;
      waited       <= 8'h00;
    end else begin
      o_disp_ready <= 1'b0;
      waited       <= waited + {7'h00, i_disp_valid};
    end
  end

  // Hit means nothing without ready, so it then shows the opposite level
  assign o_disp_hit = o_disp_ready ? i_hit : ~i_hit;
endmodule : pesd_dcache_model

// file: bench/pesd_top_tb.sv
// Self-checking testbench of the event select decoder
`timescale 1ns/1ps
module pesd_top_tb;
  import pesd_pkg::*;
  logic         i_clock = 1'b0;
  logic         i_rst = 1'b1;
  pesd_sel_s    i_sel [4];
  pesd_mem_ev_s i_ev;
  pesd_mem_ev_s idle;
  pesd_pf_req_s i_stream_req;
  pesd_pf_req_s i_ip_req;
  logic         i_stream_restart;
  logic         disp_ready;
  logic         disp_hit;
  logic         o_disp_valid;
  pesd_pf_req_s o_disp_req;
  logic         o_streamer_stopped;
  logic [47:0]  o_count [4];
  logic [7:0]   stall;
  logic         hit;
  int           mismatches = 0;
  int           checks = 0;

  always #4 i_clock = ~i_clock;

  pesd_top dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_sel(i_sel), .i_ev(i_ev),
    .i_stream_req(i_stream_req), .i_ip_req(i_ip_req), .i_stream_restart(i_stream_restart),
    .i_disp_ready(disp_ready), .i_disp_hit(disp_hit), .o_disp_valid(o_disp_valid),
    .o_disp_req(o_disp_req), .o_streamer_stopped(o_streamer_stopped), .o_count(o_count)
  );

  pesd_dcache_model partner (
    .i_clock(i_clock), .i_rst(i_rst), .i_disp_valid(o_disp_valid), .i_stall(stall),
    .i_hit(hit), .o_disp_ready(disp_ready), .o_disp_hit(disp_hit)
  );

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  // Holds event e for n cycles with counter g selected, expects exp added
  task automatic run_case(input int g, input logic [7:0] code, input logic [7:0] um,
                          input pesd_mem_ev_s e, input int n, input int exp);
    logic [47:0] base;
    @(negedge i_clock);
    i_sel[g] = '{1'b1, code, um};
    i_ev = idle;
    @(negedge i_clock);
    base = o_count[g];
    i_ev = e;
    repeat (n) @(negedge i_clock);
    i_ev = idle;
    @(negedge i_clock);
    check("event count", o_count[g], base + 48'(exp));
    i_sel[g] = '{1'b0, 8'h00, 8'h00};
  endtask : run_case

  function automatic pesd_mem_ev_s xlate_ev(input int k);
    pesd_mem_ev_s e;
    e = idle;
    case (k)
      0: e.walk_start = 1'b1;
      1: e.walk_done = 1'b1;
      2: e.walk_busy = 1'b1;
      3: e.second_level_translation_buffer_hit = 1'b1;
      4: e.pde_miss = 1'b1;
      5: e.large_walk_done = 1'b1;
      default: e.nested_walk_busy = 1'b1;
    endcase
    return e;
  endfunction : xlate_ev

  task automatic push(input logic ipv, input logic stv, input logic [25:0] line);
    @(negedge i_clock);
    i_ip_req = '{ipv, 1'b0, line};
    i_stream_req = '{stv, 1'b1, line ^ 26'h100};
  endtask : push

  task automatic quiet_drain;
    @(negedge i_clock);
    i_ip_req = '0;
    i_stream_req = '0;
    stall = 8'h00;
    for (int k = 0; k < 40 && o_disp_valid !== 1'b0; k++) @(negedge i_clock);
    repeat (2) @(negedge i_clock);
    check("queue empty", {47'h0, o_disp_valid}, 48'h0);
  endtask : quiet_drain

  task automatic test_reset;
    check("count at reset", o_count[0], 48'h0);
    check("valid at reset", {47'h0, o_disp_valid}, 48'h0);
    check("stopped at reset", {47'h0, o_streamer_stopped}, 48'h0);
    @(negedge i_clock);
    i_rst = 1'b0;
  endtask : test_reset

  task automatic test_writeback;
    pesd_mem_ev_s e;
    pesd_line_e   st [4] = '{PESD_LINE_I, PESD_LINE_S, PESD_LINE_E, PESD_LINE_M};
    e = idle;
    e.wb_valid = 1'b1;
    for (int k = 0; k < 4; k++) begin
      e.wb_state = st[k];
      run_case(0, 8'h28, 8'h01 << k, e, 3, 3);
      run_case(0, 8'h28, 8'h01 << ((k + 1) % 4), e, 2, 0);
      run_case(0, 8'h28, 8'h0f, e, 2, 2);
    end
    run_case(0, 8'h28, 8'h03, e, 2, 0);
  endtask : test_writeback

  task automatic test_cache_cycles;
    pesd_mem_ev_s e;
    e = idle;
    e.llc_miss = 1'b1;
    e.llc_ref = 1'b1;
    run_case(0, 8'h2e, 8'h41, e, 3, 3);
    run_case(0, 8'h2e, 8'h4f, e, 3, 3);
    e.llc_miss = 1'b0;
    run_case(0, 8'h2e, 8'h41, e, 2, 0);
    run_case(0, 8'h2e, 8'h4f, e, 2, 2);
    e = idle;
    e.halted = 1'b0;
    run_case(0, 8'h3c, 8'h00, e, 5, 5);
    run_case(0, 8'h3c, 8'h01, e, 5, 0);
    e.tsc_tick = 1'b1;
    run_case(0, 8'h3c, 8'h01, e, 4, 4);
    e.halted = 1'b1;
    run_case(0, 8'h3c, 8'h01, e, 4, 0);
    run_case(0, 8'h3c, 8'h00, e, 4, 0);
  endtask : test_cache_cycles

  task automatic test_translation;
    pesd_mem_ev_s others;
    logic [7:0]   codes [7] = '{8'h49, 8'h49, 8'h49, 8'h49, 8'h49, 8'h49, 8'h4f};
    logic [7:0]   masks [7] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h20, 8'h80, 8'h10};
    for (int k = 0; k < 7; k++) begin
      others = idle;
      for (int j = 0; j < 7; j++) begin
        if (j != k) begin
          others = pesd_mem_ev_s'(others | xlate_ev(j));
        end
      end
      run_case(0, codes[k], masks[k], xlate_ev(k), 4, 4);
      run_case(0, codes[k], masks[k], others, 3, 0);
    end
    run_case(0, 8'h49, 8'h08, pesd_mem_ev_s'(others | xlate_ev(6)), 3, 0);
  endtask : test_translation

  task automatic test_restricted;
    pesd_mem_ev_s e;
    logic [47:0]  base;
    e = idle;
    e.load_hit_pre = 1'b1;
    run_case(0, 8'h4c, 8'h01, e, 3, 3);
    run_case(3, 8'h4c, 8'h01, e, 3, 0);
    e = idle;
    e.wb_valid = 1'b1;
    @(negedge i_clock);
    i_sel[1] = '{1'b0, 8'h28, 8'h0f};
    base = o_count[1];
    i_ev = e;
    repeat (3) @(negedge i_clock);
    i_ev = idle;
    @(negedge i_clock);
    check("disabled count", o_count[1], base);
  endtask : test_restricted

  // Slow cache side lets six triggers pile into four entries
  task automatic test_queue_overflow;
    logic [47:0] trig;
    logic [47:0] disp;
    logic [47:0] high;
    @(negedge i_clock);
    i_sel[0] = '{1'b1, 8'h4e, 8'h04};
    i_sel[1] = '{1'b1, 8'h4e, 8'h01};
    i_sel[2] = '{1'b1, 8'h4e, 8'h04};
    stall = 8'hc8;
    hit = 1'b0;
    @(negedge i_clock);
    trig = o_count[0];
    disp = o_count[1];
    high = o_count[2];
    for (int k = 1; k <= 6; k++) push(1'b1, k == 4, 26'(k));
    @(negedge i_clock);
    i_ip_req = '0;
    i_stream_req = '0;
    repeat (2) @(negedge i_clock);
    check("triggers", o_count[0], trig + 48'h6);
    check("high counter", o_count[2], high);
    check("queue valid", {47'h0, o_disp_valid}, 48'h1);
    check("head line", {22'h0, o_disp_req.line}, 48'h3);
    check("head kind", {46'h0, o_disp_req.valid, o_disp_req.streamer}, 48'h2);
    quiet_drain;
    check("dispatches", o_count[1], disp + 48'h4);
    i_sel = '{default: '0};
  endtask : test_queue_overflow

  task automatic test_streamer;
    logic [47:0] miss;
    logic [47:0] trig;
    @(negedge i_clock);
    i_sel[0] = '{1'b1, 8'h4e, 8'h02};
    i_sel[1] = '{1'b1, 8'h4e, 8'h04};
    stall = 8'h02;
    hit = 1'b1;
    @(negedge i_clock);
    miss = o_count[0];
    trig = o_count[1];
    push(1'b1, 1'b0, 26'h10);
    quiet_drain;
    check("ip hit stop", {47'h0, o_streamer_stopped}, 48'h0);
    push(1'b0, 1'b1, 26'h20);
    quiet_drain;
    check("stream hit stop", {47'h0, o_streamer_stopped}, 48'h1);
    check("hit misses", o_count[0], miss);
    push(1'b0, 1'b1, 26'h30);
    quiet_drain;
    check("stopped triggers", o_count[1], trig + 48'h2);
    @(negedge i_clock);
    i_stream_restart = 1'b1;
    @(negedge i_clock);
    i_stream_restart = 1'b0;
    check("restart", {47'h0, o_streamer_stopped}, 48'h0);
    hit = 1'b0;
    push(1'b0, 1'b1, 26'h40);
    quiet_drain;
    check("misses", o_count[0], miss + 48'h1);
    check("triggers", o_count[1], trig + 48'h3);
    i_sel = '{default: '0};
  endtask : test_streamer

  initial begin
    #200000;
    mismatches++;
    complete_run;
  end

  initial begin
    idle = '0;
    idle.wb_state = PESD_LINE_I;
    idle.halted = 1'b1;
    i_ev = idle;
    i_sel = '{default: '0};
    i_stream_req = '0;
    i_ip_req = '0;
    i_stream_restart = 1'b0;
    stall = 8'h00;
    hit = 1'b0;
    repeat (3) @(negedge i_clock);
    test_reset;
    test_writeback;
    test_cache_cycles;
    test_translation;
    test_restricted;
    test_queue_overflow;
    test_streamer;
    complete_run;
  end
endmodule : pesd_top_tb
